// >>> rtl/scs_regs.svh
// Purpose: Named constants for the SMBus command port, both ends.
// Assumes: 25 MHz core clock, clock of the link made by the host end.
// Notes:   Header holds definitions only.
//
// What this block does
// - Slave answers at address 0x20, write 0x40
// - Nine clocks per byte, MSB first, ack
// - Data moves only while clock low
// - Master ends write with a stop
// - Master NACKs last read byte, then stops
// - Direction fixed per start; never mixed
// - One to three write bytes, 1-2 read
// - Command code sets data byte count
// - First written byte loads address pointer
// - Write byte stores data at pointer
// - Read: command, repeated start, address read
// - Every access needs fresh pointer write
// - Send, read/write byte, read/write word
// - Slave acks each byte it accepts, ninth clock; extra data bytes NACKed
// - 35 ms idle bus: release, abandon
// - Timeout only when timeout enable set
// - Send byte clears latched fault indications
// - Read word sends low byte first
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// ****************************************************************
// Addressing
// ****************************************************************
`define SCS_ADDR7      7'h20
`define SCS_ADDR_W8    8'h40

// ****************************************************************
// Byte framing
// ****************************************************************
`define SCS_LAST_BIT   4'h7
`define SCS_ACK_BIT    4'h8
`define SCS_STOP_BIT   4'h1
`define SCS_IDX_ADDR   3'h0
`define SCS_IDX_CMD    3'h1
`define SCS_IDX_D0     3'h2
`define SCS_IDX_D1     3'h3
`define SCS_IDX_D2     3'h4

// ****************************************************************
// Timing
// ****************************************************************
`define SCS_CLK_NS       40
`define SCS_CLK_KHZ      25000
`define SCS_TIMEOUT_MS   35
`define SCS_TIMEOUT_CYC  (`SCS_TIMEOUT_MS * `SCS_CLK_KHZ)
`define SCS_SCL_NS       320
`define SCS_QUARTER_CYC  (`SCS_SCL_NS / (4 * `SCS_CLK_NS))

`endif

// >>> rtl/scs_pkg.sv
// Purpose: Types shared by both ends of the SMBus command port.
// Assumes: Constants come from scs_regs.svh.
// Notes:   Types only; no numbers live here.
package scs_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [7:0] scs_byte_t;

  // Slave end states
  typedef enum logic [2:0] {
    SCS_D_IDLE,
    SCS_D_RX,
    SCS_D_RACK,
    SCS_D_TX,
    SCS_D_TACK,
    SCS_D_TLOAD
  } scs_dev_st_e;

  // Master end states
  typedef enum logic [1:0] {
    SCS_H_IDLE,
    SCS_H_START,
    SCS_H_BIT,
    SCS_H_STOP
  } scs_host_st_e;

endpackage : scs_pkg

// >>> rtl/scs_if.sv
// Purpose: Two-wire link between master end and slave end.
// Assumes: Clock line driven by master only; data line open drain.
// Notes:   Wired-AND of the data line is resolved here.
interface scs_if;

  // ****************************************************************
  // Wires
  // ****************************************************************
  logic scl;
  logic sda;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;

  // Pull-up wins unless a driver enables low
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
  modport dev  (input scl, output dev_sda_o, output dev_sda_oe_n, input sda);

endinterface : scs_if

// >>> rtl/scs_device.sv
// Purpose: Slave end of the SMBus command port.
// Assumes: Clock and data lines come from outside this clock domain.
// Notes:   No clock stretching; line changes follow a seen clock fall, except the release on a bus timeout.
`include "scs_regs.svh"

module scs_device
  import scs_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `SCS_TIMEOUT_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  scs_if.dev               bus,
  input  wire logic        i_bus_timeout_enable,
  input  wire logic        i_ptr_is_word,
  input  wire logic [15:0] i_rd_data,
  output logic      [7:0]  o_ptr,
  output logic             o_ptr_load,
  output logic             o_wr_strobe,
  output logic             o_wr_word,
  output logic      [15:0] o_wr_data,
  output logic             o_clear_faults,
  output logic             o_timeout
);

  localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (TIMEOUT_CYC < 2) begin : g_chk
    $error("TIMEOUT_CYC must be at least 2");
  end

  // ****************************************************************
  // Line synchronisers
  // ****************************************************************
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;

  // Two flops before use; third only for edge finding
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= bus.scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  logic scl_rise, scl_fall, start_seen, stop_seen, line_act;

  // Conditions: data edge while clock stays high
  assign scl_rise   = scl_s2 & ~scl_s3;
  assign scl_fall   = ~scl_s2 & scl_s3;
  assign start_seen = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_seen  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  assign line_act   = (scl_s2 ^ scl_s3) | (sda_s2 ^ sda_s3);

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  scs_dev_st_e    st_reg, st_next;
  logic [3:0]     bit_reg, bit_next;
  scs_byte_t      sh_reg, sh_next;
  logic [2:0]     idx_reg, idx_next;
  logic           rd_reg, rd_next;
  logic           fresh_reg, fresh_next;
  logic           hi_reg, hi_next;
  logic           rel_reg, rel_next;
  scs_byte_t      ptr_reg, ptr_next;
  logic [15:0]    dat_reg, dat_next;
  logic           word_reg, word_next;
  logic [TW-1:0]  tmo_reg, tmo_next;
  logic           pl_next, wr_next, clr_next, to_next;
  logic           pl_reg, wr_reg, clr_reg, to_reg;

  // Whether the byte just received earns an acknowledge
  function automatic logic ack_ok(input logic [2:0] idx, input scs_byte_t b,
                                  input logic fresh, input logic word);
    unique case (idx)
      `SCS_IDX_ADDR: ack_ok = (b[7:1] == `SCS_ADDR7) & (~b[0] | fresh);
      `SCS_IDX_CMD:  ack_ok = 1'b1;
      `SCS_IDX_D0:   ack_ok = 1'b1;
      `SCS_IDX_D1:   ack_ok = word;
      default:       ack_ok = 1'b0;
    endcase
  endfunction : ack_ok

  // Next state of the whole slave engine
  always_comb begin
    st_next    = st_reg;
    bit_next   = bit_reg;
    sh_next    = sh_reg;
    idx_next   = idx_reg;
    rd_next    = rd_reg;
    fresh_next = fresh_reg;
    hi_next    = hi_reg;
    rel_next   = rel_reg;
    ptr_next   = ptr_reg;
    dat_next   = dat_reg;
    word_next  = word_reg;
    pl_next    = 1'b0;
    wr_next    = 1'b0;
    clr_next   = 1'b0;
    to_next    = 1'b0;
    // Idle time counts only inside a transfer
    if ((st_reg == SCS_D_IDLE) || line_act) begin
      tmo_next = '0;
    end else begin
      tmo_next = tmo_reg + TW'(1);
    end
    if (i_bus_timeout_enable && (tmo_reg == TW'(TIMEOUT_CYC - 1))) begin
      st_next    = SCS_D_IDLE;
      rel_next   = 1'b1;
      fresh_next = 1'b0;
      to_next    = 1'b1;
      tmo_next   = '0;
    end else if (start_seen) begin
      // Direction is taken anew from the next address byte
      st_next  = SCS_D_RX;
      bit_next = 4'h0;
      idx_next = `SCS_IDX_ADDR;
      rel_next = 1'b1;
    end else if (stop_seen) begin
      // Commit only on a stop right after an ack; its own clock counts one
      if ((st_reg == SCS_D_RX) && (bit_reg == `SCS_STOP_BIT) && fresh_reg && !rd_reg) begin
        if (idx_reg == `SCS_IDX_D0) begin
          clr_next = 1'b1;
        end else if ((idx_reg == `SCS_IDX_D1) && !word_reg) begin
          wr_next = 1'b1;
        end else if ((idx_reg == `SCS_IDX_D2) && word_reg) begin
          wr_next = 1'b1;
        end
      end
      st_next    = SCS_D_IDLE;
      rel_next   = 1'b1;
      fresh_next = 1'b0;
    end else begin
      unique case (st_reg)
        SCS_D_IDLE: begin
        end
        SCS_D_RX: begin
          if (scl_rise) begin
            sh_next  = {sh_reg[6:0], sda_s2};
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall && (bit_reg == `SCS_ACK_BIT)) begin
            if (ack_ok(idx_reg, sh_reg, fresh_reg, word_reg)) begin
              rel_next = 1'b0;
              st_next  = SCS_D_RACK;
              idx_next = idx_reg + 3'h1;
              if (idx_reg == `SCS_IDX_ADDR) begin
                rd_next = sh_reg[0];
              end else if (idx_reg == `SCS_IDX_CMD) begin
                ptr_next   = sh_reg;
                fresh_next = 1'b1;
                pl_next    = 1'b1;
                word_next  = i_ptr_is_word;
              end else if (idx_reg == `SCS_IDX_D0) begin
                dat_next[7:0] = sh_reg;
              end else begin
                dat_next[15:8] = sh_reg;
              end
            end else begin
              // Not ours or too long: let go, wait for next condition
              st_next  = SCS_D_IDLE;
              rel_next = 1'b1;
            end
          end
        end
        SCS_D_RACK: begin
          if (scl_fall) begin
            bit_next = 4'h0;
            if (rd_reg) begin
              st_next  = SCS_D_TX;
              sh_next  = i_rd_data[7:0];
              rel_next = i_rd_data[7];
              hi_next  = i_ptr_is_word;
            end else begin
              st_next  = SCS_D_RX;
              rel_next = 1'b1;
            end
          end
        end
        SCS_D_TX: begin
          if (scl_fall) begin
            if (bit_reg == `SCS_LAST_BIT) begin
              st_next  = SCS_D_TACK;
              rel_next = 1'b1;
              bit_next = 4'h0;
            end else begin
              sh_next  = {sh_reg[6:0], 1'b0};
              rel_next = sh_reg[6];
              bit_next = bit_reg + 4'h1;
            end
          end
        end
        SCS_D_TACK: begin
          // Master low means more wanted; high ends the read
          if (scl_rise) begin
            st_next = (!sda_s2 && hi_reg) ? SCS_D_TLOAD : SCS_D_IDLE;
          end
        end
        SCS_D_TLOAD: begin
          if (scl_fall) begin
            st_next  = SCS_D_TX;
            sh_next  = i_rd_data[15:8];
            rel_next = i_rd_data[15];
            hi_next  = 1'b0;
            bit_next = 4'h0;
          end
        end
      endcase
    end
  end

  // Registers of the slave engine
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg    <= SCS_D_IDLE;
      bit_reg   <= 4'h0;
      sh_reg    <= 8'h00;
      idx_reg   <= `SCS_IDX_ADDR;
      rd_reg    <= 1'b0;
      fresh_reg <= 1'b0;
      hi_reg    <= 1'b0;
      rel_reg   <= 1'b1;
      ptr_reg   <= 8'h00;
      dat_reg   <= 16'h0000;
      word_reg  <= 1'b0;
      tmo_reg   <= '0;
      pl_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      clr_reg   <= 1'b0;
      to_reg    <= 1'b0;
    end else begin
      st_reg    <= st_next;
      bit_reg   <= bit_next;
      sh_reg    <= sh_next;
      idx_reg   <= idx_next;
      rd_reg    <= rd_next;
      fresh_reg <= fresh_next;
      hi_reg    <= hi_next;
      rel_reg   <= rel_next;
      ptr_reg   <= ptr_next;
      dat_reg   <= dat_next;
      word_reg  <= word_next;
      tmo_reg   <= tmo_next;
      pl_reg    <= pl_next;
      wr_reg    <= wr_next;
      clr_reg   <= clr_next;
      to_reg    <= to_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Open drain: value is always low, enable low while pulling
  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_sda_oe_n = rel_reg;
  assign o_ptr            = ptr_reg;
  assign o_ptr_load       = pl_reg;   // Pointer alone never writes
  assign o_wr_strobe      = wr_reg;
  assign o_wr_word        = word_reg;
  assign o_wr_data        = dat_reg;
  assign o_clear_faults   = clr_reg;
  assign o_timeout        = to_reg;

endmodule : scs_device

// >>> rtl/scs_host.sv
// Purpose: Master end of the SMBus command port.
// Assumes: Makes the link clock from the core clock by a divider.
// Notes:   One transaction per request; pointer always written first.
`include "scs_regs.svh"

module scs_host
  import scs_pkg::*;
#(
  parameter int unsigned QUARTER_CYC = `SCS_QUARTER_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  scs_if.host              bus,
  input  wire logic        i_req,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_cmd,
  input  wire logic [1:0]  i_len,
  input  wire logic [15:0] i_wdata,
  output logic             o_ready,
  output logic             o_done,
  output logic             o_nack,
  output logic      [15:0] o_rdata
);

  localparam int unsigned QW = $clog2(QUARTER_CYC + 1);

  if (QUARTER_CYC < 1) begin : g_chk
    $error("QUARTER_CYC must be at least 1");
  end

  // ****************************************************************
  // Divider and data line synchroniser
  // ****************************************************************
  logic [QW-1:0] q_reg, q_next;
  logic          tick, sda_s1, sda_s2;

  // Quarter-bit enable pulse
  always_comb begin
    tick   = (q_reg == QW'(QUARTER_CYC - 1));
    q_next = tick ? '0 : q_reg + QW'(1);
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q_reg  <= '0;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      q_reg  <= q_next;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  scs_host_st_e st_reg, st_next;
  logic [1:0]   ph_reg, ph_next;
  logic [3:0]   bit_reg, bit_next;
  scs_byte_t    sh_reg, sh_next;
  logic [2:0]   n_reg, n_next;
  logic         rph_reg, rph_next;
  logic         scl_reg, scl_next, sda_reg, sda_next;
  logic         rd_reg, rd_next;
  logic [1:0]   len_reg, len_next;
  scs_byte_t    cmd_reg, cmd_next;
  logic [15:0]  wd_reg, wd_next, rdat_reg, rdat_next;
  logic         nack_reg, nack_next, done_next, done_reg;
  logic         rx;

  // Byte to send as number n of the write phase
  function automatic scs_byte_t tx_byte(input logic [2:0] n, input scs_byte_t c,
                                        input logic [15:0] w);
    unique case (n)
      3'h0:    tx_byte = `SCS_ADDR_W8;
      3'h1:    tx_byte = c;
      3'h2:    tx_byte = w[7:0];
      default: tx_byte = w[15:8];
    endcase
  endfunction : tx_byte

  // Receiving while reading and past the address byte
  assign rx = rph_reg && (n_reg != 3'h0);

  always_comb begin
    st_next   = st_reg;
    ph_next   = ph_reg;
    bit_next  = bit_reg;
    sh_next   = sh_reg;
    n_next    = n_reg;
    rph_next  = rph_reg;
    scl_next  = scl_reg;
    sda_next  = sda_reg;
    rd_next   = rd_reg;
    len_next  = len_reg;
    cmd_next  = cmd_reg;
    wd_next   = wd_reg;
    rdat_next = rdat_reg;
    nack_next = nack_reg;
    done_next = 1'b0;
    if (st_reg == SCS_H_IDLE) begin
      if (i_req) begin
        st_next   = SCS_H_START;
        ph_next   = 2'h0;
        rd_next   = i_rd;
        len_next  = i_len;
        cmd_next  = i_cmd;
        wd_next   = i_wdata;
        rph_next  = 1'b0;
        nack_next = 1'b0;
      end
    end else if (tick) begin
      ph_next = ph_reg + 2'h1;
      unique case (st_reg)
        SCS_H_START: begin
          // Clock low two ticks so the slave lets go; first bit lowers clock
          unique case (ph_reg)
            2'h0: begin
              scl_next = 1'b0;
              sda_next = 1'b1;
            end
            2'h1: begin
            end
            2'h2: scl_next = 1'b1;
            default: begin
              sda_next = 1'b0;
              st_next  = SCS_H_BIT;
              bit_next = 4'h0;
              n_next   = 3'h0;
              sh_next  = rph_reg ? {`SCS_ADDR7, 1'b1} : `SCS_ADDR_W8;
            end
          endcase
        end
        SCS_H_BIT: begin
          unique case (ph_reg)
            2'h0: begin
              // Data moves only with the clock low
              scl_next = 1'b0;
              if (bit_reg == `SCS_ACK_BIT) begin
                sda_next = rx ? (n_reg[1:0] == len_reg) : 1'b1;
              end else begin
                sda_next = rx | sh_reg[7];
              end
            end
            2'h1: begin
            end
            2'h2: scl_next = 1'b1;
            default: begin
              if (bit_reg != `SCS_ACK_BIT) begin
                sh_next  = {sh_reg[6:0], sda_s2};
                bit_next = bit_reg + 4'h1;
              end else begin
                bit_next = 4'h0;
                if (rx) begin
                  rdat_next = (n_reg == 3'h1) ? {rdat_reg[15:8], sh_reg}
                                              : {sh_reg, rdat_reg[7:0]};
                end
                n_next = n_reg + 3'h1;
                if (!rx && sda_s2) begin
                  nack_next = 1'b1;
                  st_next   = SCS_H_STOP;
                end else if (rph_reg) begin
                  if (n_reg[1:0] == len_reg) begin
                    st_next = SCS_H_STOP;
                  end
                end else if (n_reg == (rd_reg ? 3'h1 : 3'h1 + {1'b0, len_reg})) begin
                  // Read switches direction only by a repeated start
                  st_next  = rd_reg ? SCS_H_START : SCS_H_STOP;
                  rph_next = rd_reg;
                end else begin
                  sh_next = tx_byte(n_reg + 3'h1, cmd_reg, wd_reg);
                end
              end
            end
          endcase
        end
        SCS_H_STOP: begin
          // Data low over two ticks of clock low, clock high, data rises
          unique case (ph_reg)
            2'h0: begin
              scl_next = 1'b0;
              sda_next = 1'b0;
            end
            2'h1: begin
            end
            2'h2: scl_next = 1'b1;
            default: begin
              sda_next  = 1'b1;
              st_next   = SCS_H_IDLE;
              done_next = 1'b1;
            end
          endcase
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg   <= SCS_H_IDLE;
      ph_reg   <= 2'h0;
      bit_reg  <= 4'h0;
      sh_reg   <= 8'h00;
      n_reg    <= 3'h0;
      rph_reg  <= 1'b0;
      scl_reg  <= 1'b1;
      sda_reg  <= 1'b1;
      rd_reg   <= 1'b0;
      len_reg  <= 2'h0;
      cmd_reg  <= 8'h00;
      wd_reg   <= 16'h0000;
      rdat_reg <= 16'h0000;
      nack_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      ph_reg   <= ph_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      n_reg    <= n_next;
      rph_reg  <= rph_next;
      scl_reg  <= scl_next;
      sda_reg  <= sda_next;
      rd_reg   <= rd_next;
      len_reg  <= len_next;
      cmd_reg  <= cmd_next;
      wd_reg   <= wd_next;
      rdat_reg <= rdat_next;
      nack_reg <= nack_next;
      done_reg <= done_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bus.scl           = scl_reg;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_sda_oe_n = sda_reg;
  assign o_ready           = (st_reg == SCS_H_IDLE);
  assign o_done            = done_reg;
  assign o_nack            = nack_reg;
  assign o_rdata           = rdat_reg;

endmodule : scs_host

// >>> testbench/scs_sva.sv
// Purpose: Link assertions for the command port.
// Assumes: One link tick is two core cycles.
// Notes:   Watches the interface wires only.
module scs_sva_chk (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Wire checks
  // ****
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // Slave moves data only well inside clock low
  a_dev_moves_low: assert property ($changed(dev_sda_oe_n) |-> !scl && !$past(scl))
    else $error("slave moved data near clock high");
  // Only the master makes start and stop
  a_high_by_host: assert property (scl && $past(scl) && $changed(sda) |-> dev_sda_oe_n)
    else $error("data moved by slave while clock high");
  // Ack or zero bit held across the clock pulse
  a_ack_hold: assert property ($fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*5])
    else $error("slave low bit too short");
  // High phase is two ticks
  a_scl_high_span: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high too short");
  // Low phase is at least one tick
  a_scl_low_span: assert property ($fell(scl) |-> !scl [*2])
    else $error("clock low too short");
  // Open drain: drivers only pull low
  a_open_drain: assert property (host_sda_o == 1'h0 && dev_sda_o == 1'h0)
    else $error("driver drives high");
  // Stop leaves the bus free for a while
  a_stop_free: assert property (scl && $rose(sda) |-> (scl && sda) [*2])
    else $error("bus not free after stop");
  // Bus released out of reset
  a_reset_idle: assert property ($fell(i_sys_rst) |-> scl && sda)
    else $error("bus not idle after reset");
endmodule : scs_sva_chk

// >>> testbench/smbus_command_slave_port_tb.sv
// Purpose: Self-checking bench for both ends of the command port.
// Assumes: QUARTER_CYC 2 gives a 320 ns link clock.
// Notes:   Timeout shortened to 200 cycles.
`define CK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module smbus_command_slave_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'h0;
  logic        sys_rst  = 1'h1;
  logic        req = 1'h0, rd = 1'h0, word = 1'h0, ready, done, nack, pl, stb, ww, cw, clr, tmo;
  logic [7:0]  cmd = 8'h00, ptr;
  logic [1:0]  len = 2'h0;
  logic        cut = 1'h0, toen = 1'h1;
  logic [15:0] wdat = 16'h0000, rdat = 16'h0000, dwd, cd, rdata;
  int          bad_count = 0, comparisons = 0, n_wr = 0, n_clr = 0, s_wr, s_clr;
  int          n_pl = 0, n_to = 0, s_pl, s_to;
  scs_if scs_if_i ();
  scs_device #(.TIMEOUT_CYC(200)) scs_device_i (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
    .bus(scs_if_i.dev), .i_bus_timeout_enable(toen), .i_ptr_is_word(word), .i_rd_data(rdat),
    .o_ptr(ptr), .o_ptr_load(pl), .o_wr_strobe(stb), .o_wr_word(ww), .o_wr_data(dwd),
    .o_clear_faults(clr), .o_timeout(tmo));
  scs_host #(.QUARTER_CYC(2)) scs_host_i (.i_core_clk(core_clk), .i_sys_rst(sys_rst | cut),
    .bus(scs_if_i.host), .i_req(req), .i_rd(rd), .i_cmd(cmd), .i_len(len), .i_wdata(wdat),
    .o_ready(ready), .o_done(done), .o_nack(nack), .o_rdata(rdata));
  scs_sva_chk scs_sva_chk_i (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .scl(scs_if_i.scl),
    .sda(scs_if_i.sda), .host_sda_o(scs_if_i.host_sda_o), .host_sda_oe_n(scs_if_i.host_sda_oe_n),
    .dev_sda_o(scs_if_i.dev_sda_o), .dev_sda_oe_n(scs_if_i.dev_sda_oe_n));
  // ****
  // Clock, tally and tasks
  // ****
  initial forever #20 core_clk = ~core_clk;
  // Tally slave pulses; capture write data at the strobe
  always @(posedge core_clk) begin
    if (stb === 1'h1) begin
      n_wr++;
      cd = dwd;
      cw = ww;
    end
    if (clr === 1'h1) n_clr++;
    if (pl === 1'h1) n_pl++;
    if (tmo === 1'h1) n_to++;
  end
  // One transaction; w doubles as read data so reads need no extra argument
  task automatic xfer(input logic r, input logic [7:0] c, input logic [1:0] l,
                      input logic [15:0] w, input logic wd);
    int n;
    n = 0;
    s_wr = n_wr;
    s_clr = n_clr;
    s_pl = n_pl;
    @(posedge core_clk);
    rd <= r;
    cmd <= c;
    len <= l;
    wdat <= w;
    rdat <= w;
    word <= wd;
    req <= 1'h1;
    @(posedge core_clk);
    req <= 1'h0;
    while (done !== 1'h1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    `CK("done", 1'h1, done)
    repeat (8) @(posedge core_clk);
  endtask : xfer
  task automatic t_write_word();
    xfer(1'h0, 8'hA5, 2'h2, 16'hBEEF, 1'h1);
    `CK("wr count", 1, n_wr - s_wr)
    `CK("wr data", 16'hBEEF, cd)
    `CK("wr word", 1'h1, cw)
    `CK("pointer", 8'hA5, ptr)
    `CK("ptr loads", 1, n_pl - s_pl)
    `CK("nack", 1'h0, nack)
  endtask : t_write_word
  task automatic t_write_byte();
    xfer(1'h0, 8'h3C, 2'h1, 16'h0096, 1'h0);
    `CK("wr count", 1, n_wr - s_wr)
    `CK("wr byte", 8'h96, cd[7:0])
    `CK("wr word", 1'h0, cw)
  endtask : t_write_byte
  task automatic t_send_byte();
    xfer(1'h0, 8'h03, 2'h0, 16'h0000, 1'h0);
    `CK("clear", 1, n_clr - s_clr)
    `CK("wr count", 0, n_wr - s_wr)
    `CK("pointer", 8'h03, ptr)
  endtask : t_send_byte
  task automatic t_read_word();
    xfer(1'h1, 8'h8B, 2'h2, 16'h1234, 1'h1);
    `CK("rd word", 16'h1234, rdata)
    `CK("rd side", 0, n_wr - s_wr + n_clr - s_clr)
    `CK("pointer", 8'h8B, ptr)
  endtask : t_read_word
  task automatic t_over_len();
    xfer(1'h0, 8'h40, 2'h2, 16'h5555, 1'h0);
    `CK("nack", 1'h1, nack)
    `CK("wr count", 0, n_wr - s_wr)
  endtask : t_over_len
  task automatic t_read_byte();
    xfer(1'h1, 8'h21, 2'h1, 16'h00C7, 1'h0);
    `CK("rd byte", 8'hC7, rdata[7:0])
    `CK("nack", 1'h0, nack)
  endtask : t_read_byte
  // Master cut mid-byte while sending a one: slave left waiting on a quiet bus
  task automatic t_timeout();
    toen <= 1'h0;
    s_to = n_to;
    s_wr = n_wr;
    @(posedge core_clk);
    rd <= 1'h0;
    cmd <= 8'h5A;
    len <= 2'h1;
    wdat <= 16'h0011;
    word <= 1'h0;
    req <= 1'h1;
    @(posedge core_clk);
    req <= 1'h0;
    repeat (3) @(negedge scs_if_i.scl);
    repeat (2) @(posedge core_clk);
    cut <= 1'h1;
    repeat (2) @(posedge core_clk);
    cut <= 1'h0;
    repeat (250) @(posedge core_clk);
    `CK("timeout off", 0, n_to - s_to)
    toen <= 1'h1;
    repeat (300) @(posedge core_clk);
    `CK("timeout", 1, n_to - s_to)
    `CK("wr count", 0, n_wr - s_wr)
    `CK("ready", 1'h1, ready)
  endtask : t_timeout
  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Guard against a hung transfer
  initial begin
    #300us;
    bad_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'h0;
    repeat (4) @(posedge core_clk);
    t_write_word();
    t_write_byte();
    t_send_byte();
    t_read_word();
    t_over_len();
    t_read_byte();
    t_timeout();
    report_and_stop();
  end
endmodule : smbus_command_slave_port_tb
